// ==== rtl/pll_stat_pkg.sv ====
// pll status readback: shared constants, field layout and carrier types
// assumes a 32-bit classic wishbone slave and byte addresses of 8 bits
package pll_stat_pkg;

  // ==========================================================
  // register indices, byte address is four times the index
  // ==========================================================
  localparam logic [5:0] IDX_CFG  = 6'h1a; // threshold configuration
  localparam logic [5:0] IDX_STAT = 6'h1f; // pll_monitor_status
  localparam logic [5:0] IDX_EVT  = 6'h30; // sticky change events
  localparam logic [5:0] IDX_MASK = 6'h31; // interrupt mask

  // ==========================================================
  // field positions of pll_monitor_status
  // ==========================================================
  localparam int BIT_LOCK     = 0; // digital lock detect
  localparam int BIT_PRI_ABV  = 1; // primary_reference above threshold
  localparam int BIT_SEC_ABV  = 2; // secondary_reference above threshold
  localparam int BIT_VCO_ABV  = 3; // vco above threshold
  localparam int BIT_SEC_SEL  = 4; // secondary_reference drives the pll
  localparam int BIT_HOLD     = 5; // holdover state active
  localparam int BIT_CAL_DONE = 6; // vco calibration finished
  localparam int BIT_THR_SEL  = 6; // threshold select in config register

  localparam int MON_W = 7; // monitored conditions

  // ==========================================================
  // reset values
  // ==========================================================
  localparam logic [MON_W-1:0] RST_MON  = 7'h00;
  localparam logic             RST_THR  = 1'b0;
  localparam logic [MON_W-1:0] RST_MASK = 7'h00;
  localparam logic [MON_W-1:0] RST_EVT  = 7'h00;

  // ==========================================================
  // carrier: one bit per monitored condition, packed at its bit
  // ==========================================================
  typedef struct packed {
    logic cal_done;  // bit 6
    logic holdover;  // bit 5
    logic sec_sel;   // bit 4
    logic vco_abv;   // bit 3
    logic sec_abv;   // bit 2
    logic pri_abv;   // bit 1
    logic lock;      // bit 0
  } mon_t;

endpackage : pll_stat_pkg

// ==== rtl/mon_sync.sv ====
// three-stage synchroniser with agreement filter for monitor levels
// assumes inputs arrive from other clock domains or from pins
`timescale 1ns/1ns
module mon_sync
  import pll_stat_pkg::*;
(
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // asynchronous levels in, filtered levels out
  input  wire logic [MON_W-1:0] raw_i,
  output logic      [MON_W-1:0] q_o
);

  // ==========================================================
  // stages
  // ==========================================================
  logic [MON_W-1:0] s1_ff;  // metastable stage, read by s2 only
  logic [MON_W-1:0] s2_ff;  // second stage
  logic [MON_W-1:0] s3_ff;  // third stage
  logic [MON_W-1:0] q_ff;   // accepted value
  logic [MON_W-1:0] nxt_q;  // next accepted value

  // accept a bit only when stages two and three agree
  always_comb begin
    nxt_q = (s3_ff & ~(s2_ff ^ s3_ff)) | (q_ff & (s2_ff ^ s3_ff));
  end

  // plain registers, no logic between s1 and s2
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_ff <= RST_MON;
      s2_ff <= RST_MON;
      s3_ff <= RST_MON;
      q_ff  <= RST_MON;
    end else begin
      s1_ff <= raw_i;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      q_ff  <= nxt_q;
    end
  end

  assign q_o = q_ff;

endmodule : mon_sync

// ==== rtl/evt_irq.sv ====
// sticky event bits, write-one-to-clear, mask and level interrupt
// assumes clear and mask strobes are single-cycle from the bus slave
`timescale 1ns/1ns
module evt_irq
  import pll_stat_pkg::*;
(
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // event pulses from the status logic
  input  wire logic [MON_W-1:0] ev_i,
  // software access
  input  wire logic [MON_W-1:0] clr_i,
  input  wire logic             mask_we_i,
  input  wire logic [MON_W-1:0] mask_d_i,
  // state out
  output logic      [MON_W-1:0] pend_o,
  output logic      [MON_W-1:0] mask_o,
  output logic                  irq_o
);

  // ==========================================================
  // state
  // ==========================================================
  logic [MON_W-1:0] pend_ff;   // sticky events
  logic [MON_W-1:0] mask_ff;   // 1 lets the event through
  logic             irq_ff;    // registered interrupt level
  logic [MON_W-1:0] nxt_pend;
  logic [MON_W-1:0] nxt_mask;
  logic             nxt_irq;

  // set wins over clear so a coincident event is never lost
  always_comb begin
    nxt_pend = (pend_ff & ~clr_i) | ev_i;
    nxt_mask = mask_we_i ? mask_d_i : mask_ff;
    nxt_irq  = |(pend_ff & mask_ff);
  end

  // registers only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_ff <= RST_EVT;
      mask_ff <= RST_MASK;
      irq_ff  <= 1'b0;
    end else begin
      pend_ff <= nxt_pend;
      mask_ff <= nxt_mask;
      irq_ff  <= nxt_irq;
    end
  end

  assign pend_o = pend_ff;
  assign mask_o = mask_ff;
  assign irq_o  = irq_ff;

endmodule : evt_irq

// ==== rtl/pll_status_readback.sv ====
// pll status readback: wishbone slave exposing live pll monitor state
// assumes monitor levels arrive asynchronously from the analogue side,
// and a classic wishbone master with one outstanding request
`timescale 1ns/1ns

// Notes on behaviour
// - bit 5 shows holdover state, read only
// - holdover bit ignores holdover enable setting
// - bit 4 high when secondary_reference selected
// - bit 3 high when vco above threshold
// - bit 2 secondary_reference above selected threshold
// - bit 1 primary_reference above selected threshold
// - bit 0 shows digital lock detect
// - bit 6 shows vco calibration finished
module pll_status_readback
  import pll_stat_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone classic slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // monitor conditions, asynchronous levels
  input  wire logic        holdover_active_i,
  input  wire logic        secondary_reference_sel_i,
  input  wire logic        vco_above_i,
  input  wire logic        secondary_reference_above_i,
  input  wire logic        primary_reference_above_i,
  input  wire logic        lock_detect_i,
  input  wire logic        cal_done_i,
  // to the frequency monitors and the cpu
  output logic             thr_sel_o,
  output logic             irq_o
);

  // ==========================================================
  // helpers
  // ==========================================================
  // word index of a byte address
  function automatic logic [5:0] word_idx(input logic [7:0] adr);
    word_idx = adr[7:2];
  endfunction : word_idx

  // ==========================================================
  // monitor synchronisation
  // ==========================================================
  mon_t             raw;      // gathered asynchronous inputs
  logic [MON_W-1:0] mon_q;    // filtered, in clk_i domain
  mon_t             mon;      // filtered, as struct

  // holdover bit takes the state itself, never the enable
  always_comb begin
    raw.cal_done = cal_done_i;
    raw.holdover = holdover_active_i;
    raw.sec_sel  = secondary_reference_sel_i;
    raw.vco_abv  = vco_above_i;
    raw.sec_abv  = secondary_reference_above_i;
    raw.pri_abv  = primary_reference_above_i;
    raw.lock     = lock_detect_i;
  end

  mon_sync u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .raw_i (raw),
    .q_o   (mon_q)
  );

  assign mon = mon_t'(mon_q);

  // ==========================================================
  // bus handshake
  // ==========================================================
  logic        ack_ff;    // answer, one cycle wide
  logic [31:0] dat_ff;    // read data, valid with ack
  logic        nxt_ack;
  logic [31:0] nxt_dat;
  logic        req;       // request present and not yet answered
  logic        wr_now;    // write takes effect at this edge
  logic [5:0]  idx;       // decoded word index
  logic [7:0]  rd_byte;   // selected register contents

  // answer one cycle after the request, then drop for a cycle;
  // the write lands on the edge where the master samples ack
  always_comb begin
    idx     = word_idx(adr_i);
    req     = cyc_i & stb_i & ~ack_ff;
    wr_now  = cyc_i & stb_i & ack_ff & we_i & sel_i[0];
    nxt_ack = req;
    nxt_dat = 32'h0000_0000;
    if (req && !we_i) begin
      nxt_dat = {24'h00_0000, rd_byte};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= nxt_ack;
      dat_ff <= nxt_dat;
    end
  end

  assign ack_o = ack_ff;
  assign dat_o = dat_ff;

  // ==========================================================
  // configuration register: threshold select
  // ==========================================================
  logic thr_ff;   // selects the reference frequency threshold
  logic nxt_thr;

  // only byte lane 0 carries register data
  always_comb begin
    nxt_thr = thr_ff;
    if (wr_now && idx == IDX_CFG) begin
      nxt_thr = dat_i[BIT_THR_SEL];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      thr_ff <= RST_THR;
    end else begin
      thr_ff <= nxt_thr;
    end
  end

  assign thr_sel_o = thr_ff;

  // ==========================================================
  // change events and interrupt
  // ==========================================================
  logic [MON_W-1:0] prev_ff;   // status as seen last cycle
  logic [MON_W-1:0] ev;        // any status bit changed
  logic [MON_W-1:0] evt_clr;   // write-one-to-clear strobe
  logic             mask_we;   // mask write strobe
  logic [MON_W-1:0] pend;      // sticky events
  logic [MON_W-1:0] mask;      // interrupt mask

  // each edge of a status bit is an event, both directions
  always_comb begin
    ev      = mon_q ^ prev_ff;
    evt_clr = (wr_now && idx == IDX_EVT) ? dat_i[MON_W-1:0] : RST_EVT;
    mask_we = wr_now && idx == IDX_MASK;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_ff <= RST_MON;
    end else begin
      prev_ff <= mon_q;
    end
  end

  evt_irq u_evt (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .ev_i      (ev),
    .clr_i     (evt_clr),
    .mask_we_i (mask_we),
    .mask_d_i  (dat_i[MON_W-1:0]),
    .pend_o    (pend),
    .mask_o    (mask),
    .irq_o     (irq_o)
  );

  // ==========================================================
  // read mux
  // ==========================================================
  // status has no write path at all, so writes leave it alone
  always_comb begin
    unique case (idx)
      IDX_STAT: rd_byte = {1'b0, mon_q};
      IDX_CFG:  rd_byte = {1'b0, thr_ff, 6'h00};
      IDX_EVT:  rd_byte = {1'b0, pend};
      IDX_MASK: rd_byte = {1'b0, mask};
      default:  rd_byte = 8'h00;   // unmapped reads as zero
    endcase
  end

  // ==========================================================
  // checks
  // ==========================================================
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_hold_level: assert property (
    holdover_active_i [*5] |-> mon.holdover)
    else $error("holdover bit low while holdover active");

  chk_hold_clear: assert property (
    !holdover_active_i [*5] |-> !mon.holdover)
    else $error("holdover bit high while not in holdover");

  chk_ref_sel: assert property (
    $stable(secondary_reference_sel_i) [*5] |->
      mon.sec_sel == secondary_reference_sel_i)
    else $error("reference select bit wrong");

  chk_vco_above: assert property (
    vco_above_i [*5] |-> mon.vco_abv)
    else $error("vco above bit not set");

  chk_sec_above: assert property (
    $rose(secondary_reference_above_i) ##1
      secondary_reference_above_i [*4] |-> ##[0:2] mon.sec_abv)
    else $error("secondary reference above bit late");

  chk_pri_above: assert property (
    !primary_reference_above_i [*5] |-> !mon.pri_abv)
    else $error("primary reference above bit stuck");

  chk_lock_follow: assert property (
    $fell(lock_detect_i) ##1 !lock_detect_i [*4] |-> ##[0:2] !mon.lock)
    else $error("lock bit still high after loss of lock");

  chk_cal_done: assert property (
    cal_done_i [*5] |-> mon.cal_done)
    else $error("calibration finished bit not set");

  chk_stat_readback: assert property (
    (req && !we_i && idx == IDX_STAT) |=>
      ack_o && dat_o == {25'h000_0000, $past(mon_q)})
    else $error("status readback differs from live state");

  chk_ack_single: assert property (
    ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");

  chk_irq_level: assert property (
    |(pend & mask) |=> irq_o)
    else $error("interrupt not raised for unmasked event");

  // other side of each level too, so a bit stuck at either value is caught;
  // five stable cycles cover the four-edge synchroniser latency
  chk_vco_below: assert property (
    !vco_above_i [*5] |-> !mon.vco_abv)
    else $error("vco above bit set while vco below threshold");

  chk_sec_below: assert property (
    !secondary_reference_above_i [*5] |-> !mon.sec_abv)
    else $error("secondary reference above bit stuck");

  chk_pri_set: assert property (
    primary_reference_above_i [*5] |-> mon.pri_abv)
    else $error("primary reference above bit not set");

  chk_lock_gain: assert property (
    lock_detect_i [*5] |-> mon.lock)
    else $error("lock bit low while pll locked");

  chk_cal_pending: assert property (
    !cal_done_i [*5] |-> !mon.cal_done)
    else $error("calibration finished bit set too early");

  // bus timing: answer exactly one cycle after the request edge
  chk_ack_answer: assert property (
    req |=> ack_o)
    else $error("request not answered in the next cycle");

  chk_dat_idle: assert property (
    !ack_o |-> dat_o == 32'h0000_0000)
    else $error("read data not zero outside ack");

  // config bit follows a lane-0 write and nothing else
  chk_thr_write: assert property (
    (wr_now && idx == IDX_CFG) |=>
      thr_sel_o == $past(dat_i[BIT_THR_SEL]))
    else $error("threshold select not written");

  chk_thr_keep: assert property (
    !(wr_now && idx == IDX_CFG) |=> $stable(thr_sel_o))
    else $error("threshold select changed without a write");

  chk_stat_write: assert property (
    (cyc_i && stb_i && ack_o && we_i && idx == IDX_STAT) |=>
      $stable(mask) && $stable(thr_sel_o))
    else $error("status write disturbed another register");

  // events: a status change always lands, even beside a clear
  chk_evt_set: assert property (
    (mon_q != prev_ff) |=>
      (pend & $past(ev)) == $past(ev))
    else $error("status change did not set its event bit");

  chk_irq_drop: assert property (
    !(|(pend & mask)) |=> !irq_o)
    else $error("interrupt high with no unmasked event");

  cov_lock_gain: cover property ($rose(mon.lock));
  cov_holdover: cover property ($rose(mon.holdover));
  cov_stat_read: cover property (ack_o && !we_i && idx == IDX_STAT);
  cov_irq: cover property ($rose(irq_o));
  cov_thr_write: cover property (wr_now && idx == IDX_CFG);

endmodule : pll_status_readback

// ==== testbench/tb_pll_status_readback.sv ====
// bench for pll_status_readback: wishbone tasks and directed tests
// assumes the design answers every request; the master waits for ack
`timescale 1ns/1ns
module tb_pll_status_readback;
  import pll_stat_pkg::*;

  // ==========================================================
  // compare helper
  // ==========================================================
  `define CHK(got, exp) begin \
    total_checks++; \
    if ((got) !== (exp)) begin \
      num_errors++; \
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp); \
    end \
  end

  logic        clk_i;   // bench clock
  logic        rst_i;   // synchronous reset
  logic        cyc;     // wishbone cycle
  logic        stb;     // wishbone strobe
  logic        we;      // write enable
  logic [7:0]  adr;     // byte address
  logic [3:0]  sel;     // byte enables
  logic [31:0] dat_w;   // write data
  logic [31:0] dat_o;   // read data
  logic        ack_o;   // answer
  logic        thr_sel_o;
  logic        irq_o;
  mon_t        mon_ff;  // monitor levels driven at the pins
  logic [31:0] rd;      // last read value
  int          num_errors;
  int          total_checks;

  // ==========================================================
  // device under test
  // ==========================================================
  pll_status_readback dut_u (
    .clk_i                      (clk_i),
    .rst_i                      (rst_i),
    .cyc_i                      (cyc),
    .stb_i                      (stb),
    .we_i                       (we),
    .adr_i                      (adr),
    .sel_i                      (sel),
    .dat_i                      (dat_w),
    .dat_o                      (dat_o),
    .ack_o                      (ack_o),
    .holdover_active_i          (mon_ff.holdover),
    .secondary_reference_sel_i  (mon_ff.sec_sel),
    .vco_above_i                (mon_ff.vco_abv),
    .secondary_reference_above_i(mon_ff.sec_abv),
    .primary_reference_above_i  (mon_ff.pri_abv),
    .lock_detect_i              (mon_ff.lock),
    .cal_done_i                 (mon_ff.cal_done),
    .thr_sel_o                  (thr_sel_o),
    .irq_o                      (irq_o)
  );

  // ==========================================================
  // clock and watchdog
  // ==========================================================
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  // tests need well under 2000 cycles; allow ten times that
  initial begin
    #1000000;
    num_errors++;
    finish_test();
  end

  // ==========================================================
  // bus tasks: hold request until ack, then release one cycle
  // ==========================================================
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    cyc   <= 1'b1;
    stb   <= 1'b1;
    we    <= w;
    adr   <= a;
    dat_w <= d;
    sel   <= s;
    // ack sampled at the rising edge; only the watchdog ends a hang
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    // read data taken at the very edge that shows ack high
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    // one idle cycle, so a written register has settled on return
    @(posedge clk_i);
  endtask : bus

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000, 4'hf);
    `CHK(rd, e)
  endtask : rd_chk

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_i);
  endtask : wait_clk

  // ==========================================================
  // verdict, the only place the run ends
  // ==========================================================
  task automatic finish_test();
    $display("checks=%0d errors=%0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test

  // ==========================================================
  // main sequence
  // ==========================================================
  initial begin
    num_errors = 0;
    total_checks = 0;
    rst_i = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    dat_w = 32'h0000_0000;
    mon_ff = '0;
    wait_clk(8);
    rst_i <= 1'b0;
    wait_clk(1);
    // reset state of every register and of the interrupt output
    rd_chk(8'h7c, 32'h0000_0000);
    rd_chk(8'h68, 32'h0000_0000);
    rd_chk(8'hc0, 32'h0000_0000);
    rd_chk(8'hc4, 32'h0000_0000);
    `CHK(irq_o, 1'b0)
    $display("test reset done");

    // one condition at a time lands on its own bit only
    for (int i = 0; i < MON_W; i++) begin
      mon_ff <= mon_t'(7'h01 << i);
      wait_clk(8);
      rd_chk(8'h7c, 32'h1 << i);
    end
    mon_ff <= '0;
    wait_clk(8);
    rd_chk(8'h7c, 32'h0000_0000);
    `CHK(irq_o, 1'b0) // mask is clear, so no interrupt yet
    $display("test status bits done");

    // writes of either polarity leave the status untouched
    mon_ff <= mon_t'(7'h55);
    wait_clk(8);
    bus(1'b1, 8'h7c, 32'h0000_00aa, 4'hf);
    rd_chk(8'h7c, 32'h0000_0055);
    bus(1'b1, 8'h7c, 32'hffff_ffff, 4'hf);
    rd_chk(8'h7c, 32'h0000_0055);
    mon_ff <= '0;
    wait_clk(8);
    $display("test read only done");

    // threshold select drives the monitors, byte enable honoured
    bus(1'b1, 8'h68, 32'h0000_0040, 4'h1);
    `CHK(thr_sel_o, 1'b1)
    rd_chk(8'h68, 32'h0000_0040);
    bus(1'b1, 8'h68, 32'h0000_0000, 4'he);
    `CHK(thr_sel_o, 1'b1)
    bus(1'b1, 8'h68, 32'h0000_0000, 4'hf);
    `CHK(thr_sel_o, 1'b0)
    // unmapped place answers zero and keeps nothing
    bus(1'b1, 8'h10, 32'h0000_00ff, 4'hf);
    rd_chk(8'h10, 32'h0000_0000);
    $display("test config done");

    // interrupt: clear, mask, raise, clear, masked event
    bus(1'b1, 8'hc0, 32'h0000_007f, 4'hf);
    rd_chk(8'hc0, 32'h0000_0000);
    bus(1'b1, 8'hc4, 32'h0000_0001, 4'hf);
    rd_chk(8'hc4, 32'h0000_0001);
    mon_ff.lock <= 1'b1;
    wait_clk(8);
    rd_chk(8'hc0, 32'h0000_0001);
    `CHK(irq_o, 1'b1)
    bus(1'b1, 8'hc0, 32'h0000_0001, 4'hf);
    wait_clk(2);
    `CHK(irq_o, 1'b0)
    rd_chk(8'hc0, 32'h0000_0000);
    bus(1'b1, 8'hc4, 32'h0000_0000, 4'hf);
    mon_ff.lock <= 1'b0;
    wait_clk(8);
    rd_chk(8'hc0, 32'h0000_0001);
    `CHK(irq_o, 1'b0)
    $display("test interrupt done");

    finish_test();
  end

endmodule : tb_pll_status_readback
